// ---- rtl/pull_ctl_cfg.svh ----
// Offsets, field positions and reset values of the port 3 pull registers.
// Assumes inclusion by the package, by port3_pull_ctl and by the bench.
`ifndef PULL_CTL_CFG_SVH
`define PULL_CTL_CFG_SVH

`define PULL_SELECT_ADDR     16'hF08C
`define PULL_POWERDOWN_ADDR  16'hF08D
`define PULL_SELECT_RESET    8'hFC
`define PULL_SELECT_MASK     8'hFC
`define PULL_POWERDOWN_RESET 8'h00
`define PULL_POWERDOWN_MASK  8'hFF
`define PULL_FIRST_DUAL_PIN  2
`define PULL_PIN_COUNT       8

`endif

// ---- rtl/pull_ctl_pkg.sv ----
// Types shared by the port 3 pull resistor control.
// Assumes pull_ctl_cfg.svh holds the numeric constants.
`include "pull_ctl_cfg.svh"

package pull_ctl_pkg;

	typedef logic [7:0] byte_t;

	// Per-pin resistor enables toward the pads
	typedef struct packed {
		logic [`PULL_PIN_COUNT-1:0] pullup_en;
		logic [`PULL_PIN_COUNT-1:0] pulldown_en;
	} pad_pull_s;

endpackage

// ---- rtl/pull_pin_decode.sv ----
// Resistor decode for one port 3 pin from its select and power-down bits.
// Inputs are the parent's next-state values, not registers; output is combinational and registered by the parent.
`timescale 1ns/100ps

module pull_pin_decode #(
	parameter bit DUAL = 1'b1     // Pin has both resistors
) (
	input  wire logic choice,     // 1 picks pullup, 0 pulldown
	input  wire logic off,        // Power-down or disconnect
	output logic      pullup_en,  // Pullup connected
	output logic      pulldown_en // Pulldown connected
);

	always_comb begin
		if (DUAL) begin
			pullup_en   = !off && choice;
			pulldown_en = !off && !choice;
		end else begin
			pullup_en   = !off;
			pulldown_en = 1'b0;
		end
	end

endmodule // pull_pin_decode

// ---- rtl/port3_pull_ctl.sv ----
// Port 3 pull resistor control: two registers in the MCU data space.
// Assumes a single-cycle synchronous MCU write/read port on ref_clk.
`timescale 1ns/100ps
`include "pull_ctl_cfg.svh"

module port3_pull_ctl (
	input  wire logic        ref_clk,  // 50 MHz clock
	input  wire logic        rst,      // Synchronous reset, active high
	input  wire logic        wr_en,    // Write strobe, one cycle
	input  wire logic        rd_en,    // Read strobe, one cycle
	input  wire logic [15:0] addr,     // Data-space address
	input  wire logic [7:0]  wr_data,  // Write data
	output logic      [7:0]  rd_data,  // Read data, one cycle later
	output pull_ctl_pkg::pad_pull_s pads // Resistor enables to pads
);

	pull_ctl_pkg::byte_t     sel_reg, sel_next;
	pull_ctl_pkg::byte_t     pwd_reg, pwd_next;
	pull_ctl_pkg::byte_t     rd_reg, rd_next;
	pull_ctl_pkg::pad_pull_s pads_reg, pads_next;

	always_comb begin
		sel_next = sel_reg;
		pwd_next = pwd_reg;
		rd_next  = rd_reg;
		if (wr_en && addr == `PULL_SELECT_ADDR)
			sel_next = wr_data & `PULL_SELECT_MASK;
		if (wr_en && addr == `PULL_POWERDOWN_ADDR)
			pwd_next = wr_data;
		if (rd_en) begin
			if (addr == `PULL_SELECT_ADDR)
				rd_next = sel_reg;
			else if (addr == `PULL_POWERDOWN_ADDR)
				rd_next = pwd_reg;
			else
				rd_next = 8'h00;
		end
	end

	genvar i;
	generate
		for (i = 0; i < `PULL_PIN_COUNT; i++) begin : g_pin
			pull_pin_decode #(
				.DUAL (i >= `PULL_FIRST_DUAL_PIN)
			) u_dec (
				.choice      (sel_next[i]),
				.off         (pwd_next[i]),
				.pullup_en   (pads_next.pullup_en[i]),
				.pulldown_en (pads_next.pulldown_en[i])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sel_reg  <= `PULL_SELECT_RESET;
			pwd_reg  <= `PULL_POWERDOWN_RESET;
			rd_reg   <= 8'h00;
			pads_reg <= '{pullup_en: 8'hFF, pulldown_en: 8'h00};
		end else begin
			sel_reg  <= sel_next;
			pwd_reg  <= pwd_next;
			rd_reg   <= rd_next;
			pads_reg <= pads_next;
		end
	end

	assign rd_data = rd_reg;
	assign pads    = pads_reg;

	AST_SEL_PULLUP: assert property (@(posedge ref_clk) disable iff (rst)
		(sel_reg[7:2] & ~pwd_reg[7:2]) == pads.pullup_en[7:2])
		else $error("pullup not following select");
	AST_SEL_PULLDOWN: assert property (@(posedge ref_clk) disable iff (rst)
		(~sel_reg[7:2] & ~pwd_reg[7:2]) == pads.pulldown_en[7:2])
		else $error("pulldown not following select");
	AST_RESET_SEL: assert property (@(posedge ref_clk)
		$past(rst) |-> sel_reg == 8'hFC && pads.pullup_en == 8'hFF)
		else $error("select reset value wrong");
	AST_PWD_OFF: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && addr == `PULL_POWERDOWN_ADDR && wr_data[5] |=>
		!pads.pullup_en[5] && !pads.pulldown_en[5])
		else $error("power-down left a resistor on");
	AST_ONE_RES: assert property (@(posedge ref_clk) disable iff (rst)
		(pads.pullup_en[7:2] & pads.pulldown_en[7:2]) == 6'h00)
		else $error("both resistors on one pin");
	AST_PIN01: assert property (@(posedge ref_clk) disable iff (rst)
		pads.pullup_en[1:0] == ~pwd_reg[1:0] &&
		pads.pulldown_en[1:0] == 2'h0)
		else $error("pins 0 and 1 pullup wrong");
	AST_RESET_PWD: assert property (@(posedge ref_clk)
		$past(rst) |-> pwd_reg == 8'h00)
		else $error("power-down reset value wrong");
	AST_READBACK: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && addr == `PULL_SELECT_ADDR ##1 rd_en &&
		addr == `PULL_SELECT_ADDR && !wr_en |=>
		rd_data == ($past(wr_data, 2) & 8'hFC))
		else $error("select readback wrong");
	AST_UNMAPPED_WR: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && addr != `PULL_SELECT_ADDR &&
		addr != `PULL_POWERDOWN_ADDR |=>
		$stable(sel_reg) && $stable(pwd_reg))
		else $error("unmapped write changed a register");
	AST_RD_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!rd_en |=> $stable(rd_data))
		else $error("read data moved without a read");
	AST_RD_OLD: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && rd_en && addr == `PULL_SELECT_ADDR |=>
		rd_data == $past(sel_reg))
		else $error("same-cycle read did not return old value");
	AST_SEL_LOW_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
		sel_reg[1:0] == 2'b00)
		else $error("reserved select bits not zero");
	AST_PWD_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && addr == `PULL_POWERDOWN_ADDR |=>
		pwd_reg == $past(wr_data))
		else $error("power-down write did not land");

	// Every dual pin must drop both resistors while its power-down bit is set
	generate
		for (i = `PULL_FIRST_DUAL_PIN; i < `PULL_PIN_COUNT; i++) begin : g_off
			AST_DUAL_OFF: assert property (@(posedge ref_clk) disable iff (rst)
				pwd_reg[i] |-> !pads.pullup_en[i] && !pads.pulldown_en[i])
				else $error("powered-down pin kept a resistor");
		end
	endgenerate

	COV_PULLDOWN: cover property (@(posedge ref_clk) pads.pulldown_en[7]);
	COV_READ_AFTER_WRITE: cover property (@(posedge ref_clk)
		wr_en ##1 rd_en && !wr_en);
	COV_WR_RD_SAME: cover property (@(posedge ref_clk) wr_en && rd_en);
	COV_BOTH_OFF: cover property (@(posedge ref_clk)
		!pads.pullup_en[3] && !pads.pulldown_en[3]);
	COV_PIN0_OFF: cover property (@(posedge ref_clk) !pads.pullup_en[0]);

endmodule // port3_pull_ctl

// ---- dv/test_port3_pull_ctl.sv ----
// Self-checking bench for the port 3 pull resistor control registers.
// Assumes the rtl package and modules are compiled before this file.
`timescale 1ns/100ps
`include "pull_ctl_cfg.svh"

module test_port3_pull_ctl;
	logic                    ref_clk, rst, wr_en, rd_en;
	logic [15:0]             addr;
	logic [7:0]              wr_data, rd_data;
	pull_ctl_pkg::pad_pull_s pads;
	int                      num_errors = 0;
	int                      tests_run = 0;

	port3_pull_ctl i_port3_pull_ctl (.ref_clk(ref_clk), .rst(rst),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
		.rd_data(rd_data), .pads(pads));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		step();
		wr_en = 1'b0;
		step();
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		addr = a;
		rd_en = 1'b1;
		step();
		rd_en = 1'b0;
		chk(rd_data, exp);
		step();
	endtask
	task automatic pads_are(input logic [7:0] up, input logic [7:0] dn);
		chk(pads.pullup_en, up);
		chk(pads.pulldown_en, dn);
	endtask
	task automatic t_reset();
		pads_are(8'hFF, 8'h00);
		rd(`PULL_SELECT_ADDR, 8'hFC);
		rd(`PULL_POWERDOWN_ADDR, 8'h00);
	endtask
	task automatic t_select();
		wr(`PULL_SELECT_ADDR, 8'hAB);
		rd(`PULL_SELECT_ADDR, 8'hA8);
		pads_are(8'hAB, 8'h54);
	endtask
	task automatic t_power();
		wr(`PULL_POWERDOWN_ADDR, 8'h3F);
		pads_are(8'h80, 8'h40);
		wr(`PULL_POWERDOWN_ADDR, 8'h01);
		pads_are(8'hAA, 8'h54);
		wr(16'hF08E, 8'hFF);
		rd(`PULL_POWERDOWN_ADDR, 8'h01);
		rd(16'hF08E, 8'h00);
	endtask
	task automatic t_order();
		wr(`PULL_POWERDOWN_ADDR, 8'hFD);
		pads_are(8'h02, 8'h00);
		wr(`PULL_SELECT_ADDR, 8'h00);
		pads_are(8'h02, 8'h00);
		wr(`PULL_POWERDOWN_ADDR, 8'h00);
		pads_are(8'h03, 8'hFC);
	endtask
	task automatic t_b2b();
		addr = `PULL_SELECT_ADDR;
		wr_data = 8'h57;
		wr_en = 1'b1;
		step();
		wr_en = 1'b0;
		rd_en = 1'b1;
		step();
		rd_en = 1'b0;
		chk(rd_data, 8'h54);
		pads_are(8'h57, 8'hA8);
		step();
		wr_data = 8'hFF;
		{wr_en, rd_en} = 2'b11;
		step();
		{wr_en, rd_en} = 2'b00;
		chk(rd_data, 8'h54);
		step();
		rd(`PULL_SELECT_ADDR, 8'hFC);
		pads_are(8'hFF, 8'h00);
	endtask
	task automatic t_rereset();
		wr(`PULL_POWERDOWN_ADDR, 8'hFF);
		pads_are(8'h00, 8'h00);
		wr(`PULL_SELECT_ADDR, 8'h00);
		rst = 1'b1;
		step();
		rst = 1'b0;
		pads_are(8'hFF, 8'h00);
		chk(rd_data, 8'h00);
		rd(`PULL_SELECT_ADDR, 8'hFC);
		rd(`PULL_POWERDOWN_ADDR, 8'h00);
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		{wr_en, rd_en, addr, wr_data} = '0;
		repeat (6) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_select();
		t_power();
		t_order();
		t_b2b();
		t_rereset();
		tally_and_finish();
	end
endmodule // test_port3_pull_ctl
